// ===== hw/gpp_ports.sv
// How it works
// - Each present data register is read/writeable anytime
// - General-purpose pins come up as inputs
// - Address/data ports carry external bus when expanded
// - Address/data data registers unmapped outside single-chip
// - Direction bit set means output; resets zero
// - Address/data direction registers unmapped outside single-chip
// - Pull enable pulls up input pins of port
// - Pull control register unmapped in peripheral mode
// - Reduced-drive register takes one write after reset
// - Reduced-drive register unmapped in peripheral mode
// - Reduced-drive bit lowers drive of port outputs
// - Bus-control pins 1:0 input-only, readable whenever the bus-control data register is mapped
// - Pin assignment overrides direction; only bits 7:2
// - Bus-control pulls on pins 7,3,2,1,0
// - Bus-control registers unmapped peripheral or emulated
// - Wake polarity set rising, clear falling; resets zero
// - Wake pull is down when polarity set
// - Wake edge interrupts only when enabled
// - Page port carries page index when emulating
// - Page port bit 3 always general purpose
// - Page registers unmapped while page emulation active
`timescale 1ns/1ns
`default_nettype none

module gpp_ports (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire logic [7:0]        addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [7:0]        rd_data,
	input  wire gpp_pkg::gpp_mode_t mode_sel,
	input  wire logic              page_emulation_enable,
	input  wire logic              bus_ctrl_emulation_enable,
	input  wire logic [15:0]       ext_ad_out,
	input  wire logic              ext_ad_oe,
	input  wire logic [7:0]        bus_ctrl_out,
	input  wire logic [7:0]        bus_ctrl_oe,
	input  wire logic [7:0]        page_index_out,
	input  wire gpp_pkg::gpp_bank_t pad_in,
	output gpp_pkg::gpp_pads_t     pads,
	output logic      [1:0]        wake_irq
);

	gpp_pkg::gpp_state_t st_ff;
	gpp_pkg::gpp_state_t nxt_st;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	logic       single_chip;
	logic       peripheral;
	logic       page_emu;
	logic [5:0] present;
	logic       pull_ctrl_present;
	logic       low_drive_present;

	always_comb begin
		single_chip = 1'b0;
		peripheral  = 1'b0;
		case (mode_sel)
			gpp_pkg::GPP_SINGLE:     single_chip = 1'b1;
			gpp_pkg::GPP_PERIPHERAL: peripheral = 1'b1;
			default:                 single_chip = 1'b0;
		endcase
		page_emu = !single_chip && page_emulation_enable;
		present[gpp_pkg::GPP_PORT_A] = single_chip;
		present[gpp_pkg::GPP_PORT_B] = single_chip;
		present[gpp_pkg::GPP_PORT_E] = !peripheral
			&& !(!single_chip && bus_ctrl_emulation_enable);
		present[gpp_pkg::GPP_PORT_H] = 1'b1;
		present[gpp_pkg::GPP_PORT_J] = 1'b1;
		present[gpp_pkg::GPP_PORT_K] = !page_emu;
		pull_ctrl_present = !peripheral;
		low_drive_present = !peripheral;
	end

	// ------------------------------------------------------------
	// Effective direction and read-back view
	// ------------------------------------------------------------
	gpp_pkg::gpp_bank_t dir_eff;
	gpp_pkg::gpp_bank_t pin_view;

	always_comb begin
		dir_eff = st_ff.dir;
		dir_eff[gpp_pkg::GPP_PORT_E] = st_ff.dir[gpp_pkg::GPP_PORT_E]
			& gpp_pkg::GPP_BUS_CTRL_DIR_M & ~st_ff.pin_assign;
		for (int p = 0; p < gpp_pkg::GPP_NPORT; p++) begin
			pin_view[p] = (st_ff.sync2[p] & ~dir_eff[p])
				| (st_ff.data[p] & dir_eff[p]);
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic [1:0][7:0] wake_hit;
	logic [7:0]      rd_val;
	gpp_pkg::gpp_pads_t pv;

	always_comb begin
		nxt_st   = st_ff;
		wake_hit = '0;
		rd_val   = 8'h00;
		pv       = '0;
		if (ce) begin
			nxt_st.sync1 = pad_in;
			nxt_st.sync2 = st_ff.sync1;
			nxt_st.prev  = st_ff.sync2;
			if (st_ff.warm != gpp_pkg::GPP_WARM_CNT) begin
				nxt_st.warm = st_ff.warm + 2'h1;
			end

			// Key wake-up edge detection
			for (int w = 0; w < gpp_pkg::GPP_NWAKE; w++) begin
				if (st_ff.warm == gpp_pkg::GPP_WARM_CNT) begin
					wake_hit[w] = (st_ff.pol[w]
						& st_ff.sync2[gpp_pkg::GPP_PORT_H + w]
						& ~st_ff.prev[gpp_pkg::GPP_PORT_H + w])
						| (~st_ff.pol[w]
						& ~st_ff.sync2[gpp_pkg::GPP_PORT_H + w]
						& st_ff.prev[gpp_pkg::GPP_PORT_H + w]);
				end
			end

			// Register writes
			if (wr_en) begin
				for (int p = 0; p < gpp_pkg::GPP_NPORT; p++) begin
					if (present[p] && addr == gpp_pkg::GPP_DATA_OFS[p]) begin
						nxt_st.data[p] = wdata;
					end else if (present[p] && addr == gpp_pkg::GPP_DIR_OFS[p]) begin
						nxt_st.dir[p] = wdata;
					end
				end
				for (int w = 0; w < gpp_pkg::GPP_NWAKE; w++) begin
					if (addr == gpp_pkg::GPP_POL_OFS[w]) begin
						nxt_st.pol[w] = wdata;
					end else if (addr == gpp_pkg::GPP_IEN_OFS[w]) begin
						nxt_st.ien[w] = wdata;
					end else if (addr == gpp_pkg::GPP_FLAG_OFS[w]) begin
						nxt_st.flag[w] = st_ff.flag[w] & ~wdata;
					end
				end
				if (addr == gpp_pkg::GPP_PIN_ASSIGN_OFS) begin
					nxt_st.pin_assign = wdata;
				end else if (addr == gpp_pkg::GPP_PULL_CTRL_OFS && pull_ctrl_present) begin
					nxt_st.pull_ctrl = wdata;
				end else if (addr == gpp_pkg::GPP_LOW_DRIVE_OFS && low_drive_present) begin
					if (!st_ff.low_drive_done) begin
						nxt_st.low_drive      = wdata;
						nxt_st.low_drive_done = 1'b1;
					end
				end
			end

			// Set wins over a clear in the same cycle
			for (int w = 0; w < gpp_pkg::GPP_NWAKE; w++) begin
				nxt_st.flag[w] = nxt_st.flag[w] | wake_hit[w];
			end

			// Register reads
			if (rd_en) begin
				for (int p = 0; p < gpp_pkg::GPP_NPORT; p++) begin
					if (present[p] && addr == gpp_pkg::GPP_DATA_OFS[p]) begin
						rd_val = pin_view[p];
					end else if (present[p] && addr == gpp_pkg::GPP_DIR_OFS[p]) begin
						rd_val = st_ff.dir[p];
					end
				end
				for (int w = 0; w < gpp_pkg::GPP_NWAKE; w++) begin
					if (addr == gpp_pkg::GPP_POL_OFS[w]) begin
						rd_val = st_ff.pol[w];
					end else if (addr == gpp_pkg::GPP_IEN_OFS[w]) begin
						rd_val = st_ff.ien[w];
					end else if (addr == gpp_pkg::GPP_FLAG_OFS[w]) begin
						rd_val = st_ff.flag[w];
					end
				end
				if (addr == gpp_pkg::GPP_PIN_ASSIGN_OFS) begin
					rd_val = st_ff.pin_assign;
				end else if (addr == gpp_pkg::GPP_PULL_CTRL_OFS && pull_ctrl_present) begin
					rd_val = st_ff.pull_ctrl;
				end else if (addr == gpp_pkg::GPP_LOW_DRIVE_OFS && low_drive_present) begin
					rd_val = st_ff.low_drive;
				end
			end
			nxt_st.rdata = rd_val;

			// Pad drive, general-purpose defaults
			pv.out = st_ff.data;
			pv.oe  = dir_eff;

			// Address/data ports in expanded and peripheral modes
			if (!single_chip) begin
				pv.out[gpp_pkg::GPP_PORT_A] = ext_ad_out[15:8];
				pv.out[gpp_pkg::GPP_PORT_B] = ext_ad_out[7:0];
				pv.oe[gpp_pkg::GPP_PORT_A]  = {8{ext_ad_oe}};
				pv.oe[gpp_pkg::GPP_PORT_B]  = {8{ext_ad_oe}};
			end

			// Bus-control pins handed to bus function
			pv.out[gpp_pkg::GPP_PORT_E] = (st_ff.data[gpp_pkg::GPP_PORT_E]
				& ~st_ff.pin_assign) | (bus_ctrl_out & st_ff.pin_assign);
			pv.oe[gpp_pkg::GPP_PORT_E] = dir_eff[gpp_pkg::GPP_PORT_E]
				| (bus_ctrl_oe & st_ff.pin_assign
				& gpp_pkg::GPP_BUS_CTRL_DIR_M);

			// Page port under emulation, bit 3 stays general purpose
			if (page_emu) begin
				pv.out[gpp_pkg::GPP_PORT_K] = (page_index_out & gpp_pkg::GPP_PAGE_EMU_M)
					| (st_ff.data[gpp_pkg::GPP_PORT_K] & ~gpp_pkg::GPP_PAGE_EMU_M);
				pv.oe[gpp_pkg::GPP_PORT_K] = gpp_pkg::GPP_PAGE_EMU_M
					| (dir_eff[gpp_pkg::GPP_PORT_K] & ~gpp_pkg::GPP_PAGE_EMU_M);
			end

			// Pull devices on input pins only
			for (int p = 0; p < gpp_pkg::GPP_NPORT; p++) begin
				pv.pull_up[p] = {8{st_ff.pull_ctrl[p]}} & ~pv.oe[p];
			end
			pv.pull_up[gpp_pkg::GPP_PORT_E] = pv.pull_up[gpp_pkg::GPP_PORT_E]
				& gpp_pkg::GPP_BUS_CTRL_PULL;
			for (int w = 0; w < gpp_pkg::GPP_NWAKE; w++) begin
				pv.pull_dn[gpp_pkg::GPP_PORT_H + w] = pv.pull_up[gpp_pkg::GPP_PORT_H + w]
					& st_ff.pol[w];
				pv.pull_up[gpp_pkg::GPP_PORT_H + w] = pv.pull_up[gpp_pkg::GPP_PORT_H + w]
					& ~st_ff.pol[w];
			end
			pv.low_drive = st_ff.low_drive[5:0];
			nxt_st.pads  = pv;

			for (int w = 0; w < gpp_pkg::GPP_NWAKE; w++) begin
				nxt_st.irq[w] = |(st_ff.flag[w] & st_ff.ien[w]);
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rd_data  = st_ff.rdata;
	assign pads     = st_ff.pads;
	assign wake_irq = st_ff.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_low_drive_once: assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff.low_drive_done && wr_en && addr == gpp_pkg::GPP_LOW_DRIVE_OFS)
		|=> $stable(st_ff.low_drive))
		else $error("reduced drive register changed after first write");

	chk_dir_drives_pin: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> pads.oe[gpp_pkg::GPP_PORT_H] == $past(st_ff.dir[gpp_pkg::GPP_PORT_H]))
		else $error("wake port one enable does not follow direction");

	chk_bus_ctrl_input: assert property (@(posedge clk) disable iff (sys_rst)
		pads.oe[gpp_pkg::GPP_PORT_E][1:0] == 2'h0)
		else $error("input-only bus control pin driven");

	chk_page_bit_three: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> pads.oe[gpp_pkg::GPP_PORT_K][3] == $past(st_ff.dir[gpp_pkg::GPP_PORT_K][3]))
		else $error("page port bit three not general purpose");

	chk_wake_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> wake_irq[0] == $past(|(st_ff.flag[0] & st_ff.ien[0])))
		else $error("wake interrupt does not follow enabled flags");

	chk_wake_pull_dir: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> (pads.pull_dn[gpp_pkg::GPP_PORT_H] & ~$past(st_ff.pol[0])) == 8'h00
		&& (pads.pull_up[gpp_pkg::GPP_PORT_H] & $past(st_ff.pol[0])) == 8'h00)
		else $error("wake pull of wrong kind");

	chk_pull_ctrl_absent: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && rd_en && mode_sel == gpp_pkg::GPP_PERIPHERAL
		&& addr == gpp_pkg::GPP_PULL_CTRL_OFS) |=> rd_data == 8'h00)
		else $error("pull control visible in peripheral mode");

	chk_addr_data_absent: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && rd_en && mode_sel != gpp_pkg::GPP_SINGLE
		&& addr == gpp_pkg::GPP_DATA_OFS[gpp_pkg::GPP_PORT_A]) |=> rd_data == 8'h00)
		else $error("address/data register visible outside single chip");

	chk_ext_bus_out: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && mode_sel == gpp_pkg::GPP_EXPANDED)
		|=> pads.out[gpp_pkg::GPP_PORT_A] == $past(ext_ad_out[15:8]))
		else $error("external address not on address/data port");

	chk_low_drive_pads: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> pads.low_drive == $past(st_ff.low_drive[5:0]))
		else $error("reduced drive not applied to ports");

	chk_pull_inputs: assert property (@(posedge clk) disable iff (sys_rst)
		(pads.pull_up[gpp_pkg::GPP_PORT_A] & pads.oe[gpp_pkg::GPP_PORT_A]) == 8'h00)
		else $error("pull-up on an output pin");

	chk_wake_armed: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && !wr_en && st_ff.warm != gpp_pkg::GPP_WARM_CNT)
		|=> st_ff.flag == $past(st_ff.flag))
		else $error("wake flag set before edge detection armed");

	chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && wake_hit[0] != 8'h00)
		|=> (st_ff.flag[0] & $past(wake_hit[0])) == $past(wake_hit[0]))
		else $error("wake edge lost against a flag clear");

	chk_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && !rd_en)
		|=> rd_data == 8'h00)
		else $error("read data present without a read");

	chk_bus_ctrl_pull: assert property (@(posedge clk) disable iff (sys_rst)
		(pads.pull_up[gpp_pkg::GPP_PORT_E]
		& ~gpp_pkg::GPP_BUS_CTRL_PULL) == 8'h00)
		else $error("pull-up on a bus control pin without one");

	chk_assign_overrides: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && st_ff.pin_assign[7] && !bus_ctrl_oe[7])
		|=> !pads.oe[gpp_pkg::GPP_PORT_E][7])
		else $error("direction bit drives a pin given to the bus");

	chk_dir_absent: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && wr_en && mode_sel != gpp_pkg::GPP_SINGLE
		&& addr == gpp_pkg::GPP_DIR_OFS[gpp_pkg::GPP_PORT_A])
		|=> $stable(st_ff.dir[gpp_pkg::GPP_PORT_A]))
		else $error("address/data direction written outside single chip");

	chk_bus_ctrl_absent: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && rd_en && addr == gpp_pkg::GPP_DIR_OFS[gpp_pkg::GPP_PORT_E]
		&& (mode_sel == gpp_pkg::GPP_PERIPHERAL
		|| (mode_sel == gpp_pkg::GPP_EXPANDED && bus_ctrl_emulation_enable)))
		|=> rd_data == 8'h00)
		else $error("bus control direction visible while absent");

	chk_page_absent: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && rd_en && mode_sel != gpp_pkg::GPP_SINGLE && page_emulation_enable
		&& addr == gpp_pkg::GPP_DIR_OFS[gpp_pkg::GPP_PORT_K]) |=> rd_data == 8'h00)
		else $error("page register visible under page emulation");

	chk_low_drive_absent: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && rd_en && mode_sel == gpp_pkg::GPP_PERIPHERAL
		&& addr == gpp_pkg::GPP_LOW_DRIVE_OFS) |=> rd_data == 8'h00)
		else $error("reduced drive visible in peripheral mode");

	chk_page_index_out: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && page_emu)
		|=> (pads.out[gpp_pkg::GPP_PORT_K] & gpp_pkg::GPP_PAGE_EMU_M)
		== ($past(page_index_out) & gpp_pkg::GPP_PAGE_EMU_M))
		else $error("page index not on page port under emulation");

	cov_wake_irq: cover property (@(posedge clk) disable iff (sys_rst)
		$rose(wake_irq[1]));

	cov_second_drive_write: cover property (@(posedge clk) disable iff (sys_rst)
		st_ff.low_drive_done && wr_en && addr == gpp_pkg::GPP_LOW_DRIVE_OFS);

	cov_page_emulation: cover property (@(posedge clk) disable iff (sys_rst)
		page_emu && ce);

	cov_bus_function: cover property (@(posedge clk) disable iff (sys_rst)
		pads.oe[gpp_pkg::GPP_PORT_E][7] && st_ff.pin_assign[7]);

	cov_absent_read: cover property (@(posedge clk) disable iff (sys_rst)
		rd_en && mode_sel == gpp_pkg::GPP_PERIPHERAL);

endmodule

`default_nettype wire

// ===== hw/gpp_pkg.sv
package gpp_pkg;

	// ------------------------------------------------------------
	// Port indices
	// ------------------------------------------------------------
	localparam int GPP_PORT_A = 0;
	localparam int GPP_PORT_B = 1;
	localparam int GPP_PORT_E = 2;
	localparam int GPP_PORT_H = 3;
	localparam int GPP_PORT_J = 4;
	localparam int GPP_PORT_K = 5;
	localparam int GPP_NPORT  = 6;
	localparam int GPP_NWAKE  = 2;

	// ------------------------------------------------------------
	// Register offsets (byte addresses, 8-bit data)
	// ------------------------------------------------------------
	localparam logic [5:0][7:0] GPP_DATA_OFS = {8'h20, 8'h18, 8'h10, 8'h08, 8'h01, 8'h00};
	localparam logic [5:0][7:0] GPP_DIR_OFS  = {8'h21, 8'h19, 8'h11, 8'h09, 8'h03, 8'h02};
	localparam logic [1:0][7:0] GPP_POL_OFS  = {8'h1a, 8'h12};
	localparam logic [1:0][7:0] GPP_IEN_OFS  = {8'h1b, 8'h13};
	localparam logic [1:0][7:0] GPP_FLAG_OFS = {8'h1c, 8'h14};
	localparam logic [7:0] GPP_PIN_ASSIGN_OFS = 8'h0a;
	localparam logic [7:0] GPP_PULL_CTRL_OFS  = 8'h0c;
	localparam logic [7:0] GPP_LOW_DRIVE_OFS  = 8'h0d;

	// ------------------------------------------------------------
	// Reset values and field masks
	// ------------------------------------------------------------
	localparam logic [7:0] GPP_REG_RST        = 8'h00;
	localparam logic [7:0] GPP_BUS_CTRL_DIR_M = 8'hfc;
	localparam logic [7:0] GPP_BUS_CTRL_PULL  = 8'h8f;
	localparam logic [7:0] GPP_PAGE_EMU_M     = 8'hf7;
	localparam logic [1:0] GPP_WARM_CNT       = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {GPP_SINGLE, GPP_EXPANDED, GPP_PERIPHERAL} gpp_mode_t;

	typedef logic [5:0][7:0] gpp_bank_t;

	typedef struct packed {
		gpp_bank_t  out;
		gpp_bank_t  oe;
		gpp_bank_t  pull_up;
		gpp_bank_t  pull_dn;
		logic [5:0] low_drive;
	} gpp_pads_t;

	typedef struct packed {
		gpp_bank_t       data;
		gpp_bank_t       dir;
		logic [7:0]      pin_assign;
		logic [7:0]      pull_ctrl;
		logic [7:0]      low_drive;
		logic            low_drive_done;
		logic [1:0][7:0] pol;
		logic [1:0][7:0] ien;
		logic [1:0][7:0] flag;
		gpp_bank_t       sync1;
		gpp_bank_t       sync2;
		gpp_bank_t       prev;
		logic [1:0]      warm;
		gpp_pads_t       pads;
		logic [7:0]      rdata;
		logic [1:0]      irq;
	} gpp_state_t;

endpackage

// ===== test/gpp_board.sv
`timescale 1ns/1ns
`default_nettype none

module gpp_board (
	input  wire gpp_pkg::gpp_pads_t pads,
	input  wire gpp_pkg::gpp_bank_t drv,
	output var  gpp_pkg::gpp_bank_t pad_in
);
	// Driven pins read back their own level, the rest the board's level
	assign pad_in = (pads.oe & pads.out) | (~pads.oe & drv);
endmodule

`default_nettype wire

// ===== test/general_purpose_ports_tb.sv
`timescale 1ns/1ns
`default_nettype none

module general_purpose_ports_tb;
	logic               clk;
	logic               sys_rst;
	logic               ce;
	logic [7:0]         addr;
	logic [7:0]         wdata;
	logic               wr_en;
	logic               rd_en;
	logic [7:0]         rd_data;
	gpp_pkg::gpp_mode_t mode_sel;
	logic               page_emu;
	logic               bus_emu;
	logic [15:0]        ext_ad_out;
	logic               ext_ad_oe;
	logic [7:0]         bc_out;
	logic [7:0]         bc_oe;
	logic [7:0]         page_out;
	gpp_pkg::gpp_bank_t pad_in;
	gpp_pkg::gpp_bank_t drv;
	gpp_pkg::gpp_pads_t pads;
	logic [1:0]         wake_irq;
	int                 failures;
	int                 compares;

	gpp_ports DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .mode_sel(mode_sel),
		.page_emulation_enable(page_emu), .bus_ctrl_emulation_enable(bus_emu),
		.ext_ad_out(ext_ad_out), .ext_ad_oe(ext_ad_oe), .bus_ctrl_out(bc_out),
		.bus_ctrl_oe(bc_oe), .page_index_out(page_out), .pad_in(pad_in), .pads(pads),
		.wake_irq(wake_irq));

	gpp_board board (.pads(pads), .drv(drv), .pad_in(pad_in));

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, e);
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrap_up;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#20000;
		failures++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		sys_rst    = 1'b1;
		ce         = 1'b1;
		addr       = 8'h00;
		wdata      = 8'h00;
		wr_en      = 1'b0;
		rd_en      = 1'b0;
		mode_sel   = gpp_pkg::GPP_SINGLE;
		page_emu   = 1'b0;
		bus_emu    = 1'b0;
		ext_ad_out = 16'h1234;
		ext_ad_oe  = 1'b0;
		bc_out     = 8'h00;
		bc_oe      = 8'h00;
		page_out   = 8'h00;
		drv        = '1;
		failures   = 0;
		compares   = 0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		w(2);
		for (int p = 0; p < gpp_pkg::GPP_NPORT; p++) begin
			chk(pads.oe[p], 8'h00);
		end
		rd(8'h02, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h12, 8'h00);
		$display("reset test done");

		wr(8'h00, 8'h5a);
		wr(8'h02, 8'h0f);
		drv[1] <= 8'h3c;
		w(4);
		chk(pads.oe[0], 8'h0f);
		chk(pads.out[0] & 8'h0f, 8'h0a);
		rd(8'h00, 8'hfa);
		rd(8'h01, 8'h3c);
		wr(8'h0c, 8'h0d);
		w(3);
		chk(pads.pull_up[0], 8'hf0);
		$display("port a b test done");

		wr(8'h0d, 8'h05);
		wr(8'h0d, 8'h3a);
		rd(8'h0d, 8'h05);
		w(2);
		chk({2'b00, pads.low_drive}, 8'h05);
		$display("drive test done");

		@(posedge clk);
		drv[2] <= 8'h03;
		wr(8'h09, 8'hff);
		w(3);
		chk(pads.oe[2], 8'hfc);
		chk(pads.pull_up[2], 8'h03);
		rd(8'h08, 8'h03);
		wr(8'h0a, 8'h80);
		w(3);
		chk(pads.oe[2], 8'h7c);
		@(posedge clk);
		bc_out <= 8'h80;
		bc_oe  <= 8'h80;
		w(3);
		chk(pads.oe[2], 8'hfc);
		chk(pads.out[2], 8'h80);
		$display("bus control test done");

		wr(8'h13, 8'h01);
		drv[3] <= 8'hfe;
		w(8);
		chk({6'h00, wake_irq}, 8'h01);
		wr(8'h14, 8'h01);
		w(3);
		chk({6'h00, wake_irq}, 8'h00);
		@(posedge clk);
		drv[3] <= 8'hfd;
		w(8);
		chk({6'h00, wake_irq}, 8'h00);
		rd(8'h14, 8'h02);
		wr(8'h12, 8'hff);
		w(3);
		chk(pads.pull_dn[3], 8'hff);
		chk(pads.pull_up[3], 8'h00);
		$display("wake test done");

		wr(8'h20, 8'h08);
		wr(8'h21, 8'h01);
		mode_sel  <= gpp_pkg::GPP_EXPANDED;
		ext_ad_oe <= 1'b1;
		page_emu  <= 1'b1;
		bus_emu   <= 1'b1;
		page_out  <= 8'h55;
		w(3);
		chk(pads.out[0], 8'h12);
		chk(pads.oe[1], 8'hff);
		chk(pads.out[5], 8'h5d);
		chk(pads.oe[5], 8'hf7);
		rd(8'h00, 8'h00);
		wr(8'h02, 8'hff);
		rd(8'h21, 8'h00);
		rd(8'h09, 8'h00);
		@(posedge clk);
		mode_sel <= gpp_pkg::GPP_PERIPHERAL;
		w(2);
		rd(8'h0c, 8'h00);
		rd(8'h0d, 8'h00);
		@(posedge clk);
		mode_sel <= gpp_pkg::GPP_SINGLE;
		w(2);
		rd(8'h02, 8'h0f);
		rd(8'h20, 8'hfe);
		$display("mode test done");

		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		wr(8'h12, 8'hff);
		wr(8'h0d, 8'h3a);
		rd(8'h0d, 8'h3a);
		rd(8'h14, 8'h00);
		rd(8'h09, 8'h00);
		chk(pads.oe[2], 8'h00);
		$display("second reset test done");
		wrap_up();
	end
endmodule

`default_nettype wire
